// *** rtl/file_mem_if.sv ***
`default_nettype none

interface file_mem_if;
  logic [file_ops_pkg::ADDR_WIDTH-1:0] addr; // byte address in data space
  logic readEn; // read strobe, data next cycle
  logic writeEn; // write strobe
  logic [file_ops_pkg::DATA_WIDTH-1:0] writeData; // byte to store
  logic [file_ops_pkg::DATA_WIDTH-1:0] readData; // registered read byte

  modport core
  (
    output addr,
    output readEn,
    output writeEn,
    output writeData,
    input readData
  );

  modport memory
  (
    input addr,
    input readEn,
    input writeEn,
    input writeData,
    output readData
  );
endinterface : file_mem_if

`default_nettype wire

// *** rtl/file_memory.sv ***
`default_nettype none

module file_memory
#(
  parameter int DEPTH = 4096
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  file_mem_if.memory port
);

  // storage array; contents are not cleared by reset
  logic [file_ops_pkg::DATA_WIDTH-1:0] store [DEPTH];
  logic [file_ops_pkg::DATA_WIDTH-1:0] readData_reg;
  logic [file_ops_pkg::DATA_WIDTH-1:0] readData_next;

  // read data held unless a new read is strobed
  always_comb
  begin
    readData_next = readData_reg;
    if (port.readEn)
    begin
      readData_next = store[port.addr];
    end
  end

  // read register resets, array only written on strobe
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      readData_reg <= file_ops_pkg::ZERO_BYTE;
    end
    else if (clockEnable)
    begin
      readData_reg <= readData_next;
    end
  end

  // array write; kept out of reset so it maps onto block ram
  always_ff @(posedge clock)
  begin
    if (clockEnable && port.writeEn)
    begin
      store[port.addr] <= port.writeData;
    end
  end

  assign port.readData = readData_reg;

endmodule : file_memory

`default_nettype wire

// *** rtl/file_ops_pkg.sv ***
`default_nettype none

package file_ops_pkg;

  // widths of the instruction word and of the data space
  localparam int INSTR_WIDTH = 16;
  localparam int DATA_WIDTH = 8;
  localparam int ADDR_WIDTH = 12;
  localparam int BANK_WIDTH = 4;

  // instruction word layout
  localparam int OPCODE6_MSB = 15;
  localparam int OPCODE6_LSB = 10;
  localparam int OPCODE7_LSB = 9;
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam int FILE_MSB = 7;
  localparam int FILE_LSB = 0;
  localparam int SIGN_BIT = 7;

  // opcode patterns: rotate is 0100_00da, set is 0110_100a
  localparam logic [5:0] ROTATE_RIGHT_NO_CARRY_OP = 6'h10;
  localparam logic [6:0] SET_ALL_ONES_OP = 7'h34;

  // destination and access bit values
  localparam logic DEST_ACCUM = 1'h0;
  localparam logic DEST_FILE = 1'h1;
  localparam logic ACCESS_FIXED = 1'h0;
  localparam logic ACCESS_BANKED = 1'h1;

  // addressing constants
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // data constants
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ACCUM_RESET = 8'h00;

  // four phases of one instruction cycle, gray coded
  typedef enum logic [1:0]
  {
    PHASE_DECODE = 2'h0,
    PHASE_READ = 2'h1,
    PHASE_PROCESS = 2'h3,
    PHASE_WRITE = 2'h2
  } phase_e;

endpackage : file_ops_pkg

`default_nettype wire

// *** rtl/rotate_and_set_file_ops.sv ***
`default_nettype none

module rotate_and_set_file_ops
#(
  parameter int MEM_DEPTH = 4096
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic instrValid,
  input wire logic [file_ops_pkg::INSTR_WIDTH-1:0] instrWord,
  input wire logic extendedEnable,
  input wire logic [file_ops_pkg::BANK_WIDTH-1:0] bankSelect,
  input wire logic [file_ops_pkg::ADDR_WIDTH-1:0] indexPointer,
  output logic instrReady,
  output logic instrDone,
  output logic [file_ops_pkg::DATA_WIDTH-1:0] accumulator,
  output logic negativeFlag,
  output logic zeroFlag
);

  // effective address of a byte operand
  function automatic logic [file_ops_pkg::ADDR_WIDTH-1:0] effectiveAddr
  (
    input logic [7:0] fileOperand,
    input logic accessBit,
    input logic extended,
    input logic [file_ops_pkg::BANK_WIDTH-1:0] bank,
    input logic [file_ops_pkg::ADDR_WIDTH-1:0] pointer
  );
    logic [file_ops_pkg::ADDR_WIDTH-1:0] result;
    result = {bank, fileOperand};
    if (accessBit == file_ops_pkg::ACCESS_FIXED)
    begin
      if (extended && fileOperand <= file_ops_pkg::INDEXED_LIMIT)
      begin
        // offset wraps inside the data space, as the pointer does
        result = pointer + {4'h0, fileOperand};
      end
      else if (fileOperand < file_ops_pkg::ACCESS_SPLIT)
      begin
        result = {file_ops_pkg::ACCESS_LOW_BANK, fileOperand};
      end
      else
      begin
        result = {file_ops_pkg::ACCESS_HIGH_BANK, fileOperand};
      end
    end
    return result;
  endfunction : effectiveAddr

  // one byte right rotate without carry
  function automatic logic [7:0] rotateRight(input logic [7:0] value);
    return {value[0], value[7:1]};
  endfunction : rotateRight

  file_mem_if memBus();

  file_memory
  #(
    .DEPTH(MEM_DEPTH)
  )
  dataMemory
  (
    .clock(clock),
    .reset(reset),
    .clockEnable(clockEnable),
    .port(memBus)
  );

  // phase sequencer and captured instruction state
  file_ops_pkg::phase_e phase_reg, phase_next;
  logic isRotate_reg, isRotate_next; // rotate captured in decode
  logic isSet_reg, isSet_next; // set captured in decode
  logic destFile_reg, destFile_next; // result goes to file when high
  logic [file_ops_pkg::ADDR_WIDTH-1:0] addr_reg, addr_next; // resolved operand
  logic [7:0] result_reg, result_next; // processed byte
  logic [7:0] accum_reg, accum_next; // working accumulator
  logic negative_reg, negative_next; // negative status flag
  logic zero_reg, zero_next; // zero status flag
  logic done_reg, done_next; // end of instruction marker

  // decode helpers
  logic [5:0] opcode6; // upper six bits for rotate
  logic [6:0] opcode7; // upper seven bits for set
  logic decodeRotate; // word is a rotate
  logic decodeSet; // word is a set
  logic accessBit; // access bit of the word

  assign opcode6 = instrWord[file_ops_pkg::OPCODE6_MSB:file_ops_pkg::OPCODE6_LSB];
  assign opcode7 = instrWord[file_ops_pkg::OPCODE6_MSB:file_ops_pkg::OPCODE7_LSB];
  assign decodeRotate = (opcode6 == file_ops_pkg::ROTATE_RIGHT_NO_CARRY_OP);
  assign decodeSet = (opcode7 == file_ops_pkg::SET_ALL_ONES_OP);
  assign accessBit = instrWord[file_ops_pkg::ACCESS_BIT];

  // next state for all groups of the sequencer
  always_comb
  begin
    phase_next = phase_reg;
    isRotate_next = isRotate_reg;
    isSet_next = isSet_reg;
    destFile_next = destFile_reg;
    addr_next = addr_reg;
    result_next = result_reg;
    accum_next = accum_reg;
    negative_next = negative_reg;
    zero_next = zero_reg;
    done_next = 1'b0;
    memBus.addr = addr_reg;
    memBus.readEn = 1'b0;
    memBus.writeEn = 1'b0;
    memBus.writeData = result_reg;
    case (phase_reg)
      file_ops_pkg::PHASE_DECODE:
      begin
        // idle in decode until a word arrives; others pass as no-ops
        if (instrValid)
        begin
          isRotate_next = decodeRotate;
          isSet_next = decodeSet;
          // set always writes the file; rotate follows its d bit
          destFile_next = decodeSet ||
            (instrWord[file_ops_pkg::DEST_BIT] == file_ops_pkg::DEST_FILE);
          addr_next = effectiveAddr(instrWord[file_ops_pkg::FILE_MSB:file_ops_pkg::FILE_LSB],
            accessBit, extendedEnable, bankSelect, indexPointer);
          phase_next = file_ops_pkg::PHASE_READ;
        end
      end
      file_ops_pkg::PHASE_READ:
      begin
        // set has no use for the old byte, so no read is strobed
        memBus.readEn = isRotate_reg;
        phase_next = file_ops_pkg::PHASE_PROCESS;
      end
      file_ops_pkg::PHASE_PROCESS:
      begin
        if (isRotate_reg)
        begin
          result_next = rotateRight(memBus.readData);
        end
        else
        begin
          result_next = file_ops_pkg::ALL_ONES;
        end
        phase_next = file_ops_pkg::PHASE_WRITE;
      end
      file_ops_pkg::PHASE_WRITE:
      begin
        if (isRotate_reg || isSet_reg)
        begin
          if (destFile_reg)
          begin
            memBus.writeEn = 1'b1;
          end
          else
          begin
            accum_next = result_reg;
          end
        end
        if (isRotate_reg)
        begin
          // only rotate touches the flags; set leaves them alone
          negative_next = result_reg[file_ops_pkg::SIGN_BIT];
          zero_next = (result_reg == file_ops_pkg::ZERO_BYTE);
        end
        done_next = 1'b1;
        phase_next = file_ops_pkg::PHASE_DECODE;
      end
      default:
      begin
        phase_next = file_ops_pkg::PHASE_DECODE;
      end
    endcase
  end

  // registers only; clock enable freezes everything
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      phase_reg <= file_ops_pkg::PHASE_DECODE;
      isRotate_reg <= 1'b0;
      isSet_reg <= 1'b0;
      destFile_reg <= 1'b0;
      addr_reg <= '0;
      result_reg <= file_ops_pkg::ZERO_BYTE;
      accum_reg <= file_ops_pkg::ACCUM_RESET;
      negative_reg <= 1'b0;
      zero_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (clockEnable)
    begin
      phase_reg <= phase_next;
      isRotate_reg <= isRotate_next;
      isSet_reg <= isSet_next;
      destFile_reg <= destFile_next;
      addr_reg <= addr_next;
      result_reg <= result_next;
      accum_reg <= accum_next;
      negative_reg <= negative_next;
      zero_reg <= zero_next;
      done_reg <= done_next;
    end
  end

  // ready is decoded from the phase register; done and data come from flip-flops
  assign instrReady = (phase_reg == file_ops_pkg::PHASE_DECODE);
  assign instrDone = done_reg;
  assign accumulator = accum_reg;
  assign negativeFlag = negative_reg;
  assign zeroFlag = zero_reg;

endmodule : rotate_and_set_file_ops

`default_nettype wire

// *** verif/rotate_and_set_file_ops_checker.sv ***
`default_nettype none

module rotate_and_set_file_ops_checker
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  input wire logic instrValid,
  input wire logic instrReady,
  input wire logic instrDone,
  input wire logic [file_ops_pkg::DATA_WIDTH-1:0] accumulator,
  input wire logic negativeFlag,
  input wire logic zeroFlag
);
  timeunit 1ns;
  timeprecision 1ns;
  // an instruction is accepted at this edge
  wire logic take = clockEnable && instrReady && instrValid;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  property p_busy;
    take |=> !instrReady [*3];
  endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_lat;
    take ##1 clockEnable [*3] |=> instrDone && instrReady;
  endproperty
  a_lat: assert property (p_lat) else $error("done late or early");
  property p_pulse;
    instrDone && clockEnable |=> !instrDone;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_rise;
    $rose(instrReady) |-> instrDone;
  endproperty
  a_rise: assert property (p_rise) else $error("ready without done");
  property p_hold;
    $changed({accumulator, negativeFlag, zeroFlag}) |-> instrDone;
  endproperty
  a_hold: assert property (p_hold) else $error("result moved alone");
  // accumulator only moves on a rotate, so flags must follow it
  property p_flags;
    $changed(accumulator) |-> negativeFlag == accumulator[7] && zeroFlag == (accumulator == 8'h00);
  endproperty
  a_flags: assert property (p_flags) else $error("flags wrong");
  property p_reset;
    disable iff (1'b0) reset |=> accumulator == 8'h00 && !negativeFlag && !zeroFlag
      && instrReady && !instrDone;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : rotate_and_set_file_ops_checker

bind rotate_and_set_file_ops rotate_and_set_file_ops_checker chk_u
(
  .clock, .reset, .clockEnable, .instrValid, .instrReady, .instrDone,
  .accumulator, .negativeFlag, .zeroFlag
);

`default_nettype wire

// *** verif/tb.sv ***
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clockEnable = 1'b1;
  logic instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic extendedEnable = 1'b0;
  logic [3:0] bankSelect = 4'h0;
  logic [11:0] indexPointer = 12'h000;
  logic instrReady, instrDone, negativeFlag, zeroFlag;
  logic [7:0] accumulator;
  logic [7:0] mem [4096]; // mirror of the data space
  logic [7:0] accModel = 8'h00;
  logic [1:0] nzModel = 2'h0;
  logic [9:0] expQ [$]; // expected accumulator and flags per instruction
  logic [11:0] phys;
  int i;
  int error_cnt = 0;
  int cmp_count = 0;
  always #25 clock = ~clock;
  rotate_and_set_file_ops dut_u
  (
    .clock, .reset, .clockEnable, .instrValid, .instrWord, .extendedEnable,
    .bankSelect, .indexPointer, .instrReady, .instrDone, .accumulator,
    .negativeFlag, .zeroFlag
  );
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task close_out;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  // offer until taken; junk words go out while busy and must be refused
  task issue(input logic [15:0] w, input logic [3:0] bs, input logic ext,
    input logic [11:0] ptr);
    int k;
    expQ.push_back({accModel, nzModel});
    for (k = 0; k < 100; k++)
    begin
      @(negedge clock);
      clockEnable = ($urandom % 4) != 0;
      instrValid = 1'b1;
      instrWord = instrReady ? w : 16'($urandom);
      bankSelect = bs;
      extendedEnable = ext;
      indexPointer = ptr;
      if (instrReady && clockEnable)
        break;
    end
  endtask : issue
  // kind 0 set, 1 rotate, 2 foreign opcode; addressing mode picked at random
  task run(input int kind, input logic d, input logic [11:0] p);
    logic [15:0] w;
    logic [7:0] f;
    logic [7:0] r;
    logic [3:0] bs;
    logic [11:0] ptr;
    logic ext;
    logic a;
    int m;
    m = $urandom % 3;
    bs = 4'($urandom);
    ext = 1'($urandom);
    ptr = 12'($urandom);
    a = 1'b0;
    f = p[7:0];
    if (m == 2)
    begin
      ext = 1'b1;
      f = 8'($urandom % 96);
      ptr = p - 12'(f);
    end
    else if (m == 1 && (p >= 12'hf60 || p < 12'h060))
    begin
      if (p < 12'h060)
        ext = 1'b0;
    end
    else
    begin
      a = 1'b1;
      bs = p[11:8];
    end
    w = (kind == 0) ? {7'h34, a, f} : {6'h10, d, a, f};
    // one opcode bit off a rotate; must stay a no-op, and a fresh address shows a slip
    if (kind == 2)
      w = w ^ (16'h0400 << ($urandom % 6));
    if (kind == 0)
      mem[p] = 8'hff;
    if (kind == 1)
    begin
      r = {mem[p][0], mem[p][7:1]};
      nzModel = {r[7], r == 8'h00};
      if (d)
        mem[p] = r;
      else
        accModel = r;
    end
    issue(w, bs, ext, ptr);
  endtask : run
  logic doneSeen = 1'b0; // pulse already compared
  // compare once per pulse at the falling edge, where outputs have settled;
  // the pulse may stand several cycles while clock enable is low
  always @(negedge clock)
  begin
    if (instrDone && !doneSeen)
      check(16'({accumulator, negativeFlag, zeroFlag}), 16'(expQ.pop_front()));
    doneSeen <= instrDone;
  end
  initial
  begin
    void'($urandom(5));
    repeat (8) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    check(16'({accumulator, negativeFlag, zeroFlag, instrReady, instrDone}), 16'h0002);
    for (i = 0; i < 40; i++)
    begin
      phys = 12'($urandom);
      run(2, 1'b0, phys);
      run(0, 1'b0, phys);
      run(1, 1'b1, phys);
      run(1, 1'b0, phys);
      $display("test %0d done", i);
    end
    @(negedge clock);
    instrValid = 1'b0;
    repeat (12) @(posedge clock);
    check(16'(expQ.size()), 16'h0000);
    // reset in the middle of an instruction must abort it and clear the results
    run(1, 1'b0, phys);
    @(negedge clock);
    reset = 1'b1;
    instrValid = 1'b0;
    repeat (8) @(negedge clock);
    reset = 1'b0;
    expQ.delete();
    accModel = 8'h00;
    nzModel = 2'h0;
    check(16'({accumulator, negativeFlag, zeroFlag, instrReady, instrDone}), 16'h0002);
    run(0, 1'b0, phys);
    run(1, 1'b0, phys);
    @(negedge clock);
    instrValid = 1'b0;
    repeat (12) @(posedge clock);
    check(16'(expQ.size()), 16'h0000);
    $display("test mid reset done");
    close_out();
  end
  // about 160 instructions of under 10 cycles each; five times that is a hang
  initial
  begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule : tb

`default_nettype wire
